// ==== clk_gate_pkg.sv ====
// Constants, types and helpers for the sleep clock gating controller
// ==========================================================================
// ==========================================================================
package clk_gate_pkg;
  // ========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_RUN_CFG = 12'h060;
  localparam logic [11:0] OFF_RUN_GATE = 12'h100;
  localparam logic [11:0] OFF_SLEEP_GATE = 12'h110;
  localparam logic [11:0] OFF_DEEP_GATE = 12'h120;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h130;
  localparam logic [11:0] OFF_IRQ_ENABLE = 12'h134;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h138;
  // ========================================================================
  // Field layout of the gating registers
  localparam int BIT_WDOG = 3;
  localparam int BIT_HIB = 6;
  localparam int BIT_RATE_LO = 8;
  localparam int BIT_RATE_HI = 9;
  localparam int BIT_ADC = 16;
  localparam int BIT_CAN = 24;
  localparam int BIT_ACG = 27;
  localparam int N_UNITS = 4;
  // Unit index to register bit: watchdog, hibernate, ADC, CAN
  localparam int UNIT_POS [0:3] = '{BIT_WDOG, BIT_HIB, BIT_ADC, BIT_CAN};
  localparam logic [31:0] GATE_WMASK = 32'h0101_0348;
  localparam logic [31:0] GATE_RST = 32'h0000_0040;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [1:0] RATE_500K = 2'h2;
  localparam logic [1:0] RATE_125K = 2'h0;
  // ========================================================================
  // Power modes
  typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_DEEP} power_mode_t;
  // Unit enables carried by one gating register word
  function automatic logic [3:0] unit_en(input logic [31:0] r);
    logic [3:0] e;
    e = 4'h0;
    for (int i = 0; i < N_UNITS; i++)
      e[i] = r[UNIT_POS[i]];
    return e;
  endfunction
endpackage

// ==== gate_mode_select.sv ====
// Picks the gating register for the current power mode per unit
`timescale 1ns/1ns
module gate_mode_select
  import clk_gate_pkg::*;
#(
  parameter int UNITS = N_UNITS
)
(
  input wire clk_gate_pkg::power_mode_t mode,
  input wire logic auto_clock_gating_select,
  input wire logic [31:0] run_gate,
  input wire logic [31:0] sleep_gate,
  input wire logic [31:0] deep_gate,
  output logic [UNITS-1:0] en,
  output logic [1:0] rate
);
  // ========================================================================
  // Register choice
  logic [31:0] chosen; // Word in force for the present mode

  // Without auto gating the run register rules in every mode
  always_comb
  begin
    chosen = run_gate;
    if (auto_clock_gating_select)
    begin
      unique case (mode)
        PM_SLEEP: chosen = sleep_gate;
        PM_DEEP: chosen = deep_gate;
        PM_RUN: chosen = run_gate;
        default: chosen = run_gate; // Unused code behaves as run
      endcase
    end
  end

  // ========================================================================
  // One enable per unit
  genvar g;
  generate
    for (g = 0; g < UNITS; g++)
    begin : g_unit
      assign en[g] = chosen[UNIT_POS[g]];
    end
  endgenerate

  // Rate field of the register in force
  assign rate = chosen[BIT_RATE_HI:BIT_RATE_LO];
endmodule

// ==== sleep_clock_gating_ctrl.sv ====
// APB gating register file, mode selection and gated-access faults
`timescale 1ns/1ns
module sleep_clock_gating_ctrl
#(
  parameter logic [1:0] MAX_RATE = clk_gate_pkg::RATE_500K
)
(
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire clk_gate_pkg::power_mode_t MODE,
  input wire logic [3:0] UNIT_REQ,
  output logic [3:0] UNIT_CLK_EN,
  output logic [3:0] UNIT_FAULT,
  output logic [1:0] ADC_RATE,
  output logic IRQ
);
  import clk_gate_pkg::*;

  // ========================================================================
  // State
  typedef struct packed {
    logic [31:0] run_gate; // Run mode gating word
    logic [31:0] sleep_gate; // Sleep mode gating word
    logic [31:0] deep_gate; // Deep-sleep gating word
    logic auto_clock_gating_select; // Auto clock gating select
    logic [3:0] irq_en; // Interrupt enables per unit
    logic [3:0] irq_stat; // Sticky fault flags per unit
    logic [31:0] rdata; // Read data held for the bus
    logic ready; // Access phase answer
    logic slverr; // Error beside the answer
    logic [3:0] clk_en; // Unit clock enables
    logic [3:0] fault; // Fault pulses to the units
    logic [1:0] rate; // ADC rate in force
    logic irq; // Interrupt level
  } state_t;

  localparam state_t RESET_STATE = '{
    run_gate: GATE_RST,
    sleep_gate: GATE_RST,
    deep_gate: GATE_RST,
    auto_clock_gating_select: CFG_RST[BIT_ACG],
    irq_en: 4'h0,
    irq_stat: 4'h0,
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slverr: 1'b0,
    clk_en: unit_en(GATE_RST),
    fault: 4'h0,
    rate: GATE_RST[BIT_RATE_HI:BIT_RATE_LO],
    irq: 1'b0
  };

  state_t st; // Registered state
  state_t next_st; // Next value of the state

  // ========================================================================
  // Helpers
  logic [3:0] sel_en; // Enables for the present mode
  logic [1:0] sel_rate; // Rate for the present mode
  logic acc; // Access phase of a transfer
  logic commit; // Edge where the transfer completes
  logic hit; // Address decodes to a register
  logic [3:0] gated_req; // Requests to unclocked units
  logic [31:0] rd_word; // Read mux result

  // Keep only writable fields and cap the rate field
  function automatic logic [31:0] gate_word(input logic [31:0] w,
                                            input logic [1:0] cap);
    logic [31:0] v;
    v = w & GATE_WMASK;
    if (v[BIT_RATE_HI:BIT_RATE_LO] > cap)
      v[BIT_RATE_HI:BIT_RATE_LO] = cap;
    return v;
  endfunction

  gate_mode_select #(
    .UNITS(N_UNITS)
  ) u_sel (
    .mode(MODE),
    .auto_clock_gating_select(st.auto_clock_gating_select),
    .run_gate(st.run_gate),
    .sleep_gate(st.sleep_gate),
    .deep_gate(st.deep_gate),
    .en(sel_en),
    .rate(sel_rate)
  );

  assign acc = PSEL & PENABLE;
  assign commit = acc & st.ready;
  // Faults are judged against the enable the unit actually sees
  assign gated_req = UNIT_REQ & ~st.clk_en;

  // ========================================================================
  // Read decode
  always_comb
  begin
    hit = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (PADDR)
      OFF_RUN_CFG: rd_word[BIT_ACG] = st.auto_clock_gating_select;
      OFF_RUN_GATE: rd_word = st.run_gate;
      OFF_SLEEP_GATE: rd_word = st.sleep_gate;
      OFF_DEEP_GATE: rd_word = st.deep_gate;
      OFF_IRQ_STATUS: rd_word[3:0] = st.irq_stat;
      OFF_IRQ_ENABLE: rd_word[3:0] = st.irq_en;
      OFF_IRQ_CLEAR: rd_word = 32'h0000_0000; // Write-only
      default: hit = 1'b0; // Unmapped address
    endcase
  end

  // ========================================================================
  // Next state
  // One wait state: the answer is prepared in the first access cycle so
  // that PRDATA and PREADY both come straight from flops.
  always_comb
  begin
    logic [3:0] clr;
    clr = 4'h0;
    next_st = st;
    next_st.ready = 1'b0;
    next_st.slverr = 1'b0;
    // First access cycle: load the answer
    if (acc && !st.ready)
    begin
      next_st.ready = 1'b1;
      next_st.rdata = rd_word;
      next_st.slverr = ~hit;
    end
    // Write takes effect at the completing edge only
    if (commit && PWRITE && !st.slverr)
    begin
      unique case (PADDR)
        OFF_RUN_CFG: next_st.auto_clock_gating_select = PWDATA[BIT_ACG];
        OFF_RUN_GATE: next_st.run_gate = gate_word(PWDATA, MAX_RATE);
        // Sleep word, writable fields all update together
        OFF_SLEEP_GATE:
          next_st.sleep_gate = gate_word(PWDATA, MAX_RATE);
        OFF_DEEP_GATE: next_st.deep_gate = gate_word(PWDATA, MAX_RATE);
        OFF_IRQ_ENABLE: next_st.irq_en = PWDATA[3:0];
        OFF_IRQ_CLEAR: clr = PWDATA[3:0];
        default: clr = 4'h0; // Status is read-only
      endcase
    end
    // A fault in the clearing cycle survives the clear
    next_st.irq_stat = (st.irq_stat & ~clr) | gated_req;
    next_st.fault = gated_req;
    next_st.clk_en = sel_en;
    next_st.rate = sel_rate;
    next_st.irq = |(next_st.irq_stat & next_st.irq_en);
  end

  // ========================================================================
  // State register
  // Reset wins over the clock enable so the part always comes up known
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      st <= RESET_STATE;
    else if (CE)
      st <= next_st;
  end

  // ========================================================================
  // Outputs
  assign PRDATA = st.rdata;
  assign PREADY = st.ready;
  assign PSLVERR = st.slverr;
  assign UNIT_CLK_EN = st.clk_en;
  assign UNIT_FAULT = st.fault;
  assign ADC_RATE = st.rate;
  assign IRQ = st.irq;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST || !CE);

  // Reserved bits never hold a one
  a_reserved_zero: assert property (
    (st.sleep_gate & ~GATE_WMASK) == 32'h0000_0000)
    else $error("Reserved sleep gating bit set");

  // Rate never above the cap
  a_rate_capped: assert property (
    st.sleep_gate[BIT_RATE_HI:BIT_RATE_LO] <= MAX_RATE)
    else $error("Sleep rate above limit");

  // Fault pulses exactly follow gated requests
  a_fault_follows: assert property (
    1'b1 |=> UNIT_FAULT == $past(UNIT_REQ & ~UNIT_CLK_EN))
    else $error("Fault does not match gated request");

  // Without auto gating the run word rules
  a_run_when_noacg: assert property (
    !st.auto_clock_gating_select |=> UNIT_CLK_EN == $past(unit_en(st.run_gate)))
    else $error("Run word not in force");

  // Sleep word rules in sleep with auto gating
  a_sleep_word: assert property (
    (st.auto_clock_gating_select && MODE == PM_SLEEP)
    |=> UNIT_CLK_EN == $past(unit_en(st.sleep_gate)))
    else $error("Sleep word not in force");

  // Deep-sleep word rules in deep sleep with auto gating
  a_deep_word: assert property (
    (st.auto_clock_gating_select && MODE == PM_DEEP)
    |=> UNIT_CLK_EN == $past(unit_en(st.deep_gate)))
    else $error("Deep-sleep word not in force");

  // Sleep word value after reset
  a_reset_value: assert property (
    $past(SRST) |-> st.sleep_gate == GATE_RST && !st.auto_clock_gating_select)
    else $error("Bad sleep word after reset");

  // Completed write lands the CAN, ADC, hibernate and watchdog bits
  a_write_lands: assert property (
    (commit && PWRITE && !st.slverr && PADDR == OFF_SLEEP_GATE)
    |=> st.sleep_gate[BIT_CAN] == $past(PWDATA[BIT_CAN])
    && st.sleep_gate[BIT_ADC] == $past(PWDATA[BIT_ADC])
    && st.sleep_gate[BIT_HIB] == $past(PWDATA[BIT_HIB])
    && st.sleep_gate[BIT_WDOG] == $past(PWDATA[BIT_WDOG]))
    else $error("Sleep write lost");

  // Answer is one cycle, one cycle after access starts
  a_ready_once: assert property (
    (acc && !PREADY) |=> PREADY ##1 !PREADY)
    else $error("Bad answer timing");

  // Sticky flag holds until cleared
  a_flag_sticky: assert property (
    (st.irq_stat[0] && !(commit && PWRITE && PADDR == OFF_IRQ_CLEAR))
    |=> st.irq_stat[0])
    else $error("Fault flag lost");

  c_sleep_write: cover property (
    commit && PWRITE && PADDR == OFF_SLEEP_GATE);
  c_gated_fault: cover property (
    st.auto_clock_gating_select && MODE == PM_SLEEP && gated_req != 4'h0);
  c_irq_raised: cover property (!IRQ ##1 IRQ);
endmodule

// ==== unit_side_model.sv ====
// Model of the peripheral units that reach into the gated clock domain
`timescale 1ns/1ns
module unit_side_model
(
  input wire logic clk,
  output logic [3:0] req
);
  // ==========================================
  // Access strobes
  // Idle strobes are low; a unit only asks when it means to
  initial req = 4'h0;
  // One-cycle access per masked unit, changed just after an edge
  task automatic access(input logic [3:0] mask);
    @(posedge clk);
    req <= mask;
    @(posedge clk);
    req <= 4'h0;
  endtask
endmodule

// ==== sleep_clock_gating_ctrl_test.sv ====
// Self-checking bench for the sleep clock gating controller
`timescale 1ns/1ns
module sleep_clock_gating_ctrl_test;
  import clk_gate_pkg::*;
  // ==========================================
  // Stimulus and observed signals
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  power_mode_t mode = PM_RUN;
  logic [3:0] req;
  logic [3:0] en;
  logic [3:0] fault;
  logic [1:0] rate;
  logic irq;
  logic [31:0] q;
  logic e;
  int fails = 0;
  int total_checks = 0;
  // Clock of 10 ns period
  always #5 clk = ~clk;
  // ==========================================
  // Instances
  sleep_clock_gating_ctrl dut_u (.SYS_CLK(clk), .SRST(srst), .CE(1'b1),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .MODE(mode), .UNIT_REQ(req), .UNIT_CLK_EN(en), .UNIT_FAULT(fault),
    .ADC_RATE(rate), .IRQ(irq));
  unit_side_model unit_u (.clk(clk), .req(req));
  // ==========================================
  // Shared tasks
  // Verdict; only place the run ends
  task automatic tally_and_finish();
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Compare one value, zero-extended to a word
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask
  // APB transfer; answer taken in the cycle where PREADY stands high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // PREADY is judged at the rising edge, the same edge the slave commits
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    // A slave that never answers ends the run
    if (n >= 50)
    begin
      fails++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read a register and compare the word
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, q);
  endtask
  // Change the power mode and let the outputs settle
  task automatic set_mode(input power_mode_t m);
    @(posedge clk);
    mode <= m;
    repeat (3) @(negedge clk);
  endtask
  // ==========================================
  // Scenarios
  // Values straight out of reset
  task automatic t_reset();
    rdchk("sleep word", OFF_SLEEP_GATE, 32'h0000_0040);
    chk("enables", 32'h2, en);
    chk("rate", 32'h0, rate);
  endtask
  // Reserved bits ignored, rate codes stored, oversize rate capped
  task automatic t_fields();
    apb(1'b1, OFF_SLEEP_GATE, 32'hFFFF_FFFF);
    rdchk("all ones", OFF_SLEEP_GATE, 32'h0101_0248);
    for (int r = 0; r < 3; r++)
    begin
      apb(1'b1, OFF_SLEEP_GATE, {22'h0, r[1:0], 8'h00});
      rdchk("rate code", OFF_SLEEP_GATE, {22'h0, r[1:0], 8'h00});
    end
  endtask
  // Word chosen by mode; sleep word only with auto gating
  task automatic t_modes();
    apb(1'b1, OFF_RUN_CFG, 32'h0800_0000);
    apb(1'b1, OFF_RUN_GATE, 32'h0);
    apb(1'b1, OFF_DEEP_GATE, 32'h0);
    for (int i = 0; i < N_UNITS; i++)
    begin
      apb(1'b1, OFF_SLEEP_GATE, 32'h1 << UNIT_POS[i]);
      set_mode(PM_SLEEP);
      chk("unit bit", 32'h1 << i, en);
    end
    apb(1'b1, OFF_SLEEP_GATE, 32'h0101_0248);
    set_mode(PM_SLEEP);
    chk("sleep en", 32'hF, en);
    chk("sleep rate", 32'h2, rate);
    set_mode(PM_DEEP);
    chk("deep en", 32'h0, en);
    apb(1'b1, OFF_RUN_CFG, 32'h0);
    set_mode(PM_SLEEP);
    chk("no auto", 32'h0, en);
  endtask
  // Gated access faults, sticky status, masked and cleared interrupt
  task automatic t_fault();
    set_mode(PM_RUN);
    apb(1'b1, OFF_RUN_GATE, 32'h1 << BIT_HIB);
    apb(1'b1, OFF_IRQ_ENABLE, 32'hF);
    unit_u.access(4'hF);
    @(negedge clk);
    chk("faults", 32'hD, fault);
    @(negedge clk);
    chk("irq set", 32'h1, irq);
    rdchk("status", OFF_IRQ_STATUS, 32'hD);
    apb(1'b1, OFF_IRQ_CLEAR, 32'hD);
    rdchk("cleared", OFF_IRQ_STATUS, 32'h0);
    chk("irq clear", 32'h0, irq);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0);
    unit_u.access(4'h1);
    repeat (2) @(negedge clk);
    chk("irq masked", 32'h0, irq);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h1);
    @(negedge clk);
    chk("irq unmask", 32'h1, irq);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h1);
    apb(1'b0, 12'h200, 32'h0);
    chk("unmapped err", 32'h1, e);
    chk("unmapped data", 32'h0, q);
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_fields();
    t_modes();
    t_fault();
    tally_and_finish();
  end
endmodule
